// ==== rtl/clos_line_output_select.sv ====
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module clos_line_output_select import clos_pkg::*; #(
  parameter int READOUT_US = 100,
  parameter int SEND_US = 500
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic trigger_input_pin_i,
  input wire logic strobe_pulse_i,
  output logic output_pin_a_o,
  output logic output_pin_b_o
);

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------

  // Maps a route code to its live source; unused codes behave as off.
  function automatic logic route_value(
    input logic [2:0] code,
    input logic [3:0] flags,
    input logic user,
    input logic strobe
  );
    logic v;
    v = 1'b0;
    unique case (code)
      ROUTE_WAIT: v = flags[0];
      ROUTE_ACTIVE: v = flags[1];
      ROUTE_TRANSFER: v = flags[2];
      ROUTE_EXPOSE: v = flags[3];
      ROUTE_USER: v = user;
      ROUTE_STROBE: v = strobe;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  clos_timing_if tif();

  logic pick_r, pick_nxt;
  logic [1:0][2:0] route_r, route_nxt;
  logic [2:0] sw_level_r, sw_level_nxt;
  logic [2:0] pol_r, pol_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic [31:0] exposure_r, exposure_nxt;
  logic [31:0] frame_r, frame_nxt;
  logic sw_trig_r, sw_trig_nxt;
  logic trig_in_r, trig_in_nxt;
  logic [1:0] line_r, line_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [3:0] flags;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------

  // Unmapped writes are dropped silently; the port never stalls the master.
  always_comb begin
    pick_nxt = pick_r;
    route_nxt = route_r;
    sw_level_nxt = sw_level_r;
    pol_nxt = pol_r;
    mode_nxt = mode_r;
    exposure_nxt = exposure_r;
    frame_nxt = frame_r;
    sw_trig_nxt = 1'b0;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFS_PIN_PICK: pick_nxt = reg_wdata_i[0];
        OFS_ROUTE: route_nxt[pick_r] = reg_wdata_i[2:0];
        OFS_SW_LEVEL: sw_level_nxt = {reg_wdata_i[2:1], 1'b0};
        OFS_POLARITY: pol_nxt = reg_wdata_i[2:0];
        OFS_MODE: mode_nxt = reg_wdata_i[3:0];
        OFS_EXPOSURE: exposure_nxt = reg_wdata_i;
        OFS_FRAME: frame_nxt = reg_wdata_i;
        OFS_SW_TRIG: sw_trig_nxt = reg_wdata_i[0];
        default: sw_trig_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pick_r <= RST_PIN_PICK;
      route_r <= {RST_ROUTE, RST_ROUTE};
      sw_level_r <= RST_SW_LEVEL;
      pol_r <= RST_POLARITY;
      mode_r <= RST_MODE;
      exposure_r <= RST_EXPOSURE_US;
      frame_r <= RST_FRAME_US;
      sw_trig_r <= 1'b0;
    end else begin
      pick_r <= pick_nxt;
      route_r <= route_nxt;
      sw_level_r <= sw_level_nxt;
      pol_r <= pol_nxt;
      mode_r <= mode_nxt;
      exposure_r <= exposure_nxt;
      frame_r <= frame_nxt;
      sw_trig_r <= sw_trig_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Frame timer hookup
  // ----------------------------------------------------------------------

  // The trigger pin is taken as synchronous; its inversion bit flips the
  // level before edge detection, so the active edge follows the polarity.
  assign tif.exp_mode = mode_r[MODE_EXP_BIT];
  assign tif.fpri_mode = mode_r[MODE_FPRI_BIT];
  assign tif.trig_mode = mode_r[MODE_TRIG_BIT];
  assign tif.trig_src = mode_r[MODE_TSRC_BIT];
  assign tif.exposure_us = exposure_r;
  assign tif.frame_us = frame_r;
  assign tif.sw_trig = sw_trig_r;
  assign tif.hw_trig = trig_in_r ^ pol_r[0];
  assign flags = {tif.expose, tif.sending, tif.active, tif.awaiting};

  clos_frame_timer #(
    .READOUT_US(READOUT_US),
    .SEND_US(SEND_US)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tif(tif.engine)
  );

  // ----------------------------------------------------------------------
  // Output lines
  // ----------------------------------------------------------------------

  // Each line is resolved on its own, so reprogramming one line can never
  // disturb the other; the cost is one cycle of latency through the flop.
  always_comb begin
    trig_in_nxt = trigger_input_pin_i;
    for (int k = 0; k < 2; k++) begin
      line_nxt[k] = route_value(route_r[k], flags, sw_level_r[k + 1], strobe_pulse_i)
                    ^ pol_r[k + 1];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_in_r <= 1'b0;
      line_r <= 2'h0;
    end else begin
      trig_in_r <= trig_in_nxt;
      line_r <= line_nxt;
    end
  end

  assign output_pin_a_o = line_r[0];
  assign output_pin_b_o = line_r[1];

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------

  // Read data stand for exactly one cycle after the strobe, zero otherwise.
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_PIN_PICK: rdata_nxt = {31'h0, pick_r};
        OFS_ROUTE: rdata_nxt = {29'h0, route_r[pick_r]};
        OFS_SW_LEVEL: rdata_nxt = {29'h0, sw_level_r};
        OFS_POLARITY: rdata_nxt = {29'h0, pol_r};
        OFS_DIRECTION: rdata_nxt = {29'h0, DIRECTION_VIEW};
        OFS_LEVEL: rdata_nxt = {29'h0, line_r, trig_in_r};
        OFS_MODE: rdata_nxt = {28'h0, mode_r};
        OFS_EXPOSURE: rdata_nxt = exposure_r;
        OFS_FRAME: rdata_nxt = frame_r;
        OFS_STATE: rdata_nxt = {28'h0, flags};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  property p_route_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_wr_i && reg_addr_i == OFS_ROUTE && !pick_r)
        |=> (route_r[0] == $past(reg_wdata_i[2:0])) && $stable(route_r[1]);
  endproperty
  a_route_write: assert property (p_route_write) else $error("Route write hit wrong line.");

  property p_pick_reset;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> !pick_r;
  endproperty
  a_pick_reset: assert property (p_pick_reset) else $error("Pick not on first line.");

  property p_user_level;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (route_r[1] == ROUTE_USER && $stable(sw_level_r) && $stable(pol_r) && $stable(route_r))
        |=> output_pin_b_o == ($past(sw_level_r[2]) ^ $past(pol_r[2]));
  endproperty
  a_user_level: assert property (p_user_level) else $error("User level not inverted.");

  property p_off_line;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (route_r[0] == ROUTE_OFF && !pol_r[1]) |=> !output_pin_a_o;
  endproperty
  a_off_line: assert property (p_off_line) else $error("Off route drives the line.");

  property p_expose_line;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (route_r[1] == ROUTE_EXPOSE) ##1 (route_r[1] == ROUTE_EXPOSE)
        |-> output_pin_b_o == ($past(tif.expose) ^ $past(pol_r[2]));
  endproperty
  a_expose_line: assert property (p_expose_line) else $error("Exposure route wrong.");

  property p_trigger_input_pin_out;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      !sw_level_r[0];
  endproperty
  a_trigger_input_pin_out: assert property (p_trigger_input_pin_out) else $error("Line zero level set.");

  property p_direction;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_rd_i && reg_addr_i == OFS_DIRECTION) |=> reg_rdata_o == 32'h00000006;
  endproperty
  a_direction: assert property (p_direction) else $error("Direction view wrong.");

  property p_level_view;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_rd_i && reg_addr_i == OFS_LEVEL)
        |=> reg_rdata_o[2:1] == {$past(output_pin_b_o), $past(output_pin_a_o)};
  endproperty
  a_level_view: assert property (p_level_view) else $error("Level view wrong.");

  property p_read_idle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      !reg_rd_i |=> reg_rdata_o == 32'h00000000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("Read data outside read slot.");

  property p_active_cover;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      tif.expose |-> tif.active && !tif.sending;
  endproperty
  a_active_cover: assert property (p_active_cover) else $error("Active flag gap.");

  // Each route is checked one cycle after the settings that pick it, matching the line flop.
  property p_wait_line;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (route_r[0] == ROUTE_WAIT)
        |=> output_pin_a_o == ($past(tif.awaiting) ^ $past(pol_r[1]));
  endproperty
  a_wait_line: assert property (p_wait_line) else $error("Trigger-wait route wrong.");

  property p_active_line;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (route_r[0] == ROUTE_ACTIVE)
        |=> output_pin_a_o == ($past(tif.active) ^ $past(pol_r[1]));
  endproperty
  a_active_line: assert property (p_active_line) else $error("Frame-active route wrong.");

  property p_transfer_line;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (route_r[0] == ROUTE_TRANSFER)
        |=> output_pin_a_o == ($past(tif.sending) ^ $past(pol_r[1]));
  endproperty
  a_transfer_line: assert property (p_transfer_line) else $error("Transfer route wrong.");

  property p_user_line;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (route_r[0] == ROUTE_USER)
        |=> output_pin_a_o == ($past(sw_level_r[1]) ^ $past(pol_r[1]));
  endproperty
  a_user_line: assert property (p_user_line) else $error("User route wrong.");

  property p_strobe_line;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (route_r[1] == ROUTE_STROBE)
        |=> output_pin_b_o == ($past(strobe_pulse_i) ^ $past(pol_r[2]));
  endproperty
  a_strobe_line: assert property (p_strobe_line) else $error("Strobe route wrong.");

  // An edge seen while waiting must open the shutter on the very next edge.
  property p_hw_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (tif.awaiting && !tif.trig_src && $rose(tif.hw_trig))
        |=> tif.expose;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("Edge did not start exposure.");

  property p_pick_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_wr_i && reg_addr_i == OFS_PIN_PICK)
        |=> pick_r == $past(reg_wdata_i[0]);
  endproperty
  a_pick_write: assert property (p_pick_write) else $error("Pick write lost.");

  property p_pol_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_wr_i && reg_addr_i == OFS_POLARITY)
        |=> pol_r == $past(reg_wdata_i[2:0]);
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("Polarity write lost.");

  property p_level_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_wr_i && reg_addr_i == OFS_SW_LEVEL)
        |=> sw_level_r == {$past(reg_wdata_i[2:1]), 1'b0};
  endproperty
  a_level_write: assert property (p_level_write) else $error("Level write wrong.");

endmodule
`default_nettype wire

// ==== rtl/clos_pkg.sv ====
package clos_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_PICK = 8'h00;
  localparam logic [7:0] OFS_ROUTE = 8'h04;
  localparam logic [7:0] OFS_SW_LEVEL = 8'h08;
  localparam logic [7:0] OFS_POLARITY = 8'h0C;
  localparam logic [7:0] OFS_DIRECTION = 8'h10;
  localparam logic [7:0] OFS_LEVEL = 8'h14;
  localparam logic [7:0] OFS_MODE = 8'h18;
  localparam logic [7:0] OFS_EXPOSURE = 8'h1C;
  localparam logic [7:0] OFS_FRAME = 8'h20;
  localparam logic [7:0] OFS_SW_TRIG = 8'h24;
  localparam logic [7:0] OFS_STATE = 8'h28;

  // ----------------------------------------------------------------------
  // Field positions of the mode register
  // ----------------------------------------------------------------------
  localparam int MODE_EXP_BIT = 0;
  localparam int MODE_FPRI_BIT = 1;
  localparam int MODE_TRIG_BIT = 2;
  localparam int MODE_TSRC_BIT = 3;

  // ----------------------------------------------------------------------
  // Output route codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] ROUTE_OFF = 3'h0;
  localparam logic [2:0] ROUTE_WAIT = 3'h1;
  localparam logic [2:0] ROUTE_ACTIVE = 3'h2;
  localparam logic [2:0] ROUTE_TRANSFER = 3'h3;
  localparam logic [2:0] ROUTE_EXPOSE = 3'h4;
  localparam logic [2:0] ROUTE_USER = 3'h5;
  localparam logic [2:0] ROUTE_STROBE = 3'h6;

  // ----------------------------------------------------------------------
  // Reset values and fixed views
  // ----------------------------------------------------------------------
  localparam logic RST_PIN_PICK = 1'b0;
  localparam logic [2:0] RST_ROUTE = 3'h0;
  localparam logic [2:0] RST_SW_LEVEL = 3'h0;
  localparam logic [2:0] RST_POLARITY = 3'h0;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [31:0] RST_EXPOSURE_US = 32'h00001F40;
  localparam logic [31:0] RST_FRAME_US = 32'h00008235;
  localparam logic [2:0] DIRECTION_VIEW = 3'h6;

  // ----------------------------------------------------------------------
  // Timing: one microsecond expressed in core clock cycles
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MICROSECOND_NS = 1000;
  localparam int US_CYCLES = (MICROSECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== rtl/clos_timing_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Configuration from the register file to the frame timer, flags back.
interface clos_timing_if;
  logic exp_mode;
  logic fpri_mode;
  logic trig_mode;
  logic trig_src;
  logic [31:0] exposure_us;
  logic [31:0] frame_us;
  logic sw_trig;
  logic hw_trig;
  logic awaiting;
  logic expose;
  logic active;
  logic sending;

  modport ctrl (
    output exp_mode, fpri_mode, trig_mode, trig_src, exposure_us, frame_us,
    output sw_trig, hw_trig,
    input awaiting, expose, active, sending
  );
  modport engine (
    input exp_mode, fpri_mode, trig_mode, trig_src, exposure_us, frame_us,
    input sw_trig, hw_trig,
    output awaiting, expose, active, sending
  );
endinterface
`default_nettype wire

// ==== rtl/clos_frame_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module clos_frame_timer import clos_pkg::*; #(
  parameter int READOUT_US = 100,
  parameter int SEND_US = 500
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  clos_timing_if.engine tif
);

  typedef enum logic [2:0] {ST_WAIT, ST_EXPOSE, ST_READOUT, ST_SEND, ST_GAP} clos_fstate_e;

  localparam logic [31:0] OVERHEAD_US = 32'(READOUT_US + SEND_US);
  localparam logic [6:0] TICK_LAST = 7'(US_CYCLES - 1);

  // A zero duration is raised to 1 us, so exposure, readout and transfer targets are at least 1 us.
  function automatic logic [31:0] clamp_min1(input logic [31:0] v);
    return (v == 32'h00000000) ? 32'h00000001 : v;
  endfunction

  clos_fstate_e state_r, state_nxt;
  logic [6:0] tick_r, tick_nxt;
  logic [31:0] st_us_r, st_us_nxt;
  logic [31:0] fr_us_r, fr_us_nxt;
  logic hw_prev_r, hw_prev_nxt;
  logic [31:0] budget_us, exp_target, st_target;
  logic tick, hw_edge, start;

  // ----------------------------------------------------------------------
  // Exposure length and state progression
  // ----------------------------------------------------------------------
  always_comb begin
    tick = (tick_r == TICK_LAST);
    hw_edge = tif.hw_trig && !hw_prev_r;
    start = tif.trig_src ? tif.sw_trig : hw_edge;
    budget_us = clamp_min1((tif.frame_us > OVERHEAD_US) ? tif.frame_us - OVERHEAD_US : 32'h0);
    if (tif.exp_mode) begin
      exp_target = budget_us;
    end else if (tif.fpri_mode && tif.exposure_us > budget_us) begin
      exp_target = budget_us;
    end else begin
      exp_target = clamp_min1(tif.exposure_us);
    end
    unique case (state_r)
      ST_EXPOSE: st_target = exp_target;
      ST_READOUT: st_target = clamp_min1(32'(READOUT_US));
      ST_SEND: st_target = clamp_min1(32'(SEND_US));
      default: st_target = tif.frame_us;
    endcase
    state_nxt = state_r;
    tick_nxt = tick ? 7'h00 : tick_r + 7'h01;
    st_us_nxt = tick ? st_us_r + 32'h1 : st_us_r;
    fr_us_nxt = tick ? fr_us_r + 32'h1 : fr_us_r;
    hw_prev_nxt = tif.hw_trig;
    unique case (state_r)
      // A trigger seen while waiting starts exposure on the next edge.
      ST_WAIT: if (!tif.trig_mode || start) state_nxt = ST_EXPOSE;
      ST_EXPOSE: if (tick && st_us_nxt >= st_target) state_nxt = ST_READOUT;
      ST_READOUT: if (tick && st_us_nxt >= st_target) state_nxt = ST_SEND;
      ST_SEND: if (tick && st_us_nxt >= st_target) state_nxt = ST_GAP;
      // Free run pads the frame; a long exposure simply stretches it.
      ST_GAP: if (tif.trig_mode || fr_us_r >= clamp_min1(tif.frame_us)) state_nxt = ST_WAIT;
    endcase
    if (state_nxt != state_r) begin
      tick_nxt = 7'h00;
      st_us_nxt = 32'h0;
    end
    if (state_nxt == ST_EXPOSE && state_r != ST_EXPOSE) begin
      fr_us_nxt = 32'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_WAIT;
      tick_r <= 7'h00;
      st_us_r <= 32'h0;
      fr_us_r <= 32'h0;
      hw_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tick_r <= tick_nxt;
      st_us_r <= st_us_nxt;
      fr_us_r <= fr_us_nxt;
      hw_prev_r <= hw_prev_nxt;
    end
  end

  // Flags decode straight from the state register; awaiting is also gated by trig_mode.
  assign tif.awaiting = tif.trig_mode && (state_r == ST_WAIT);
  assign tif.expose = (state_r == ST_EXPOSE);
  assign tif.active = (state_r == ST_EXPOSE) || (state_r == ST_READOUT);
  assign tif.sending = (state_r == ST_SEND);

  property p_sw_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_r == ST_WAIT && tif.trig_mode && tif.trig_src && tif.sw_trig) |=> tif.expose;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("Trigger did not start exposure.");

  property p_send_follows;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_r == ST_READOUT && state_nxt != ST_READOUT) |=> tif.sending && !tif.active;
  endproperty
  a_send_follows: assert property (p_send_follows) else $error("Transfer did not follow readout.");

  property p_manual_len;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (tif.expose && !tif.exp_mode && !tif.fpri_mode && state_nxt == ST_READOUT)
        |-> (st_us_r + 32'h1 == clamp_min1(tif.exposure_us));
  endproperty
  a_manual_len: assert property (p_manual_len) else $error("Exposure length wrong.");

endmodule
`default_nettype wire

// ==== verification/clos_line_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
// Stand-in for the trigger source and strobe controller wired to the camera lines.
module clos_line_partner (
  input wire logic core_clk_i,
  output logic trigger_line_o,
  output logic strobe_line_o
);
  // ----------------------------------------------------------------------
  // Line drivers
  // ----------------------------------------------------------------------
  // Both lines rest low; the equipment drives them push-pull, never floating.
  initial begin
    trigger_line_o = 1'b0;
    strobe_line_o = 1'b0;
  end

  // A long width mimics a slow controller that holds its trigger for a while.
  task automatic pulse_trigger(input int width);
    @(posedge core_clk_i);
    trigger_line_o <= 1'b1;
    repeat (width) @(posedge core_clk_i);
    trigger_line_o <= 1'b0;
  endtask

  // Strobe timer pulse arriving from outside the selector.
  task automatic pulse_strobe(input int width);
    @(posedge core_clk_i);
    strobe_line_o <= 1'b1;
    repeat (width) @(posedge core_clk_i);
    strobe_line_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top import clos_pkg::*;;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  // Short readout and transfer keep each frame under two thousand cycles.
  localparam int RD_US = 1;
  localparam int SD_US = 2;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic trig_line;
  logic strobe_line;
  logic pin_a;
  logic pin_b;
  logic [3:0] mode_tab [4] = '{4'hC, 4'hD, 4'hE, 4'hC};
  int exp_tab [4] = '{2, 2, 10, 10};
  int want_tab [4] = '{2, 3, 3, 10};
  int bad_count = 0;
  int comparisons = 0;
  int n;

  // Clock of 8 ns.
  always #4 core_clk_i = ~core_clk_i;

  clos_line_output_select #(.READOUT_US(RD_US), .SEND_US(SD_US)) clos_line_output_select_i (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata),
    .trigger_input_pin_i(trig_line),
    .strobe_pulse_i(strobe_line),
    .output_pin_a_o(pin_a),
    .output_pin_b_o(pin_b)
  );

  clos_line_partner clos_line_partner_i (
    .core_clk_i(core_clk_i),
    .trigger_line_o(trig_line),
    .strobe_line_o(strobe_line)
  );

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One-cycle write strobe; the register changes at the second edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask

  // Read data is valid only in the cycle after the strobe, so it is taken there.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    `CHK(rd_val, e)
  endtask

  // The line flop follows a register one cycle after the write edge.
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask

  // Bounded wait for a line level; running out ends the run as a failure.
  // The first look is one step late, so a line launched at this edge has settled.
  task automatic wait_pin(input logic which, input logic val, input int limit);
    #1;
    for (int i = 0; i <= limit; i++) begin
      if ((which ? pin_b : pin_a) === val) return;
      @(posedge core_clk_i);
      #1;
    end
    bad_count++;
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, ~val, val);
    give_verdict();
  endtask

  // Length in cycles of the next high pulse on a line.
  task automatic high_len(input logic which, output int len);
    wait_pin(which, 1'b1, 3000);
    len = 0;
    while ((which ? pin_b : pin_a) === 1'b1 && len < 5000) begin
      @(posedge core_clk_i);
      #1;
      len++;
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd_chk(OFS_PIN_PICK, 32'h00000000);
    rd_chk(OFS_ROUTE, 32'h00000000);
    rd_chk(OFS_SW_LEVEL, 32'h00000000);
    rd_chk(OFS_POLARITY, 32'h00000000);
    rd_chk(OFS_DIRECTION, 32'h00000006);
    @(posedge core_clk_i);
    #1;
    `CHK(reg_rdata, 32'h00000000)
    rd_chk(OFS_EXPOSURE, 32'h00001F40);
    rd_chk(OFS_FRAME, 32'h00008235);
    rd_chk(8'h3C, 32'h00000000);
    `CHK(pin_a, 1'b0)
    `CHK(pin_b, 1'b0)
    wr(OFS_EXPOSURE, 32'h00000002);
    wr(OFS_FRAME, 32'h00000006);
    // Software level with polarity; bit0 belongs to the trigger input and stays 0.
    wr(OFS_ROUTE, {29'h0, ROUTE_USER});
    wr(OFS_SW_LEVEL, 32'h00000007);
    rd_chk(OFS_SW_LEVEL, 32'h00000006);
    settle();
    `CHK(pin_a, 1'b1)
    wr(OFS_POLARITY, 32'h00000006);
    settle();
    `CHK(pin_a, 1'b0)
    `CHK(pin_b, 1'b1)
    rd_chk(OFS_LEVEL, 32'h00000004);
    // Line two carries the strobe while line one keeps its level.
    wr(OFS_PIN_PICK, 32'h00000001);
    rd_chk(OFS_ROUTE, 32'h00000000);
    wr(OFS_ROUTE, {29'h0, ROUTE_STROBE});
    wr(OFS_POLARITY, 32'h00000000);
    settle();
    fork
      clos_line_partner_i.pulse_strobe(20);
    join_none
    wait_pin(1'b1, 1'b1, 4);
    `CHK(pin_a, 1'b1)
    wait_pin(1'b1, 1'b0, 30);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_ROUTE, 32'(c));
      rd_chk(OFS_ROUTE, 32'(c));
    end
    // Line one shows trigger-wait, line two the exposure window.
    wr(OFS_ROUTE, {29'h0, ROUTE_EXPOSE});
    wr(OFS_PIN_PICK, 32'h00000000);
    wr(OFS_ROUTE, {29'h0, ROUTE_WAIT});
    for (int k = 0; k < 4; k++) begin
      wr(OFS_MODE, {28'h0, mode_tab[k]});
      wr(OFS_EXPOSURE, 32'(exp_tab[k]));
      wait_pin(1'b0, 1'b1, 20000);
      wr(OFS_SW_TRIG, 32'h00000001);
      high_len(1'b1, n);
      `CHK(n >= want_tab[k] * US_CYCLES - 1 && n <= want_tab[k] * US_CYCLES + 1, 1'b1)
    end
    // Hardware trigger starts the exposure at once while frame-active covers it.
    wr(OFS_MODE, 32'h00000004);
    rd_chk(OFS_MODE, 32'h00000004);
    wait_pin(1'b0, 1'b1, 20000);
    wr(OFS_ROUTE, {29'h0, ROUTE_ACTIVE});
    fork
      clos_line_partner_i.pulse_trigger(3);
    join_none
    wait_pin(1'b1, 1'b1, 8);
    `CHK(pin_a, 1'b1)
    rd_chk(OFS_STATE, 32'h0000000A);
    wait_pin(1'b1, 1'b0, 3000);
    `CHK(pin_a, 1'b1)
    // Sending follows the readout, after the exposure has closed.
    wr(OFS_ROUTE, {29'h0, ROUTE_TRANSFER});
    wait_pin(1'b0, 1'b1, 3000);
    `CHK(pin_b, 1'b0)
    give_verdict();
  end
endmodule
`default_nettype wire
